// ---- core/nstpf_pkg.sv ----
// constants and types shared by the status and time payload framer
package nstpf_pkg;
  // ---------------------------------------------------------------
  // packet identifiers and payload lengths in bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] ID_EPOCH = 8'h15;
  localparam logic [7:0] ID_CALENDAR = 8'h16;
  localparam logic [7:0] ID_STATUS = 8'h17;
  localparam logic [7:0] ID_POS_SD = 8'h18;
  localparam logic [7:0] ID_VEL_SD = 8'h19;
  localparam logic [3:0] LEN_EPOCH = 4'h8;
  localparam logic [3:0] LEN_CALENDAR = 4'hE;
  localparam logic [3:0] LEN_STATUS = 4'h4;
  localparam logic [3:0] LEN_SD = 4'hC;
  localparam int PAYLOAD_MAX = 14;
  localparam int PAYLOAD_BITS = PAYLOAD_MAX * 8;

  // ---------------------------------------------------------------
  // filter word field positions
  // ---------------------------------------------------------------
  localparam int FW_INIT_LSB = 0;
  localparam int FW_FIX_LSB = 4;
  localparam int FW_EVENT_LSB = 7;
  localparam int FW_AID_LSB = 9;
  localparam logic [15:0] FILTER_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // field limits
  // ---------------------------------------------------------------
  localparam logic [31:0] USEC_MAX = 32'h000F_423F;
  localparam logic [15:0] YEAR_DAY_MAX = 16'h016D;
  localparam logic [7:0] MONTH_MAX = 8'h0B;
  localparam logic [7:0] MDAY_MIN = 8'h01;
  localparam logic [7:0] MDAY_MAX = 8'h1F;
  localparam logic [7:0] WDAY_MAX = 8'h06;
  localparam logic [7:0] HOUR_MAX = 8'h17;
  localparam logic [7:0] MINSEC_MAX = 8'h3B;

  // ---------------------------------------------------------------
  // output buffer shape
  // ---------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;

  typedef enum logic [2:0] {
    FIX_NONE = 3'h0, FIX_2D = 3'h1, FIX_3D = 3'h2, FIX_SBAS = 3'h3,
    FIX_DIFF = 3'h4, FIX_PPP = 3'h5, FIX_RTK_FLOAT = 3'h6, FIX_RTK_FIXED = 3'h7
  } nstpf_fix_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1
  } nstpf_state_t;
endpackage

// ---- core/nstpf_stream_if.sv ----
// byte stream carrier between framer and output buffer
`timescale 1ns/1ns
`default_nettype none
interface nstpf_stream_if #(parameter int W = 9);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ---- core/nstpf_fifo.sv ----
// parameterised valid/ready fifo
`timescale 1ns/1ns
`default_nettype none
module nstpf_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  nstpf_stream_if.snk in_s,
  nstpf_stream_if.src out_s
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // ---------------------------------------------------------------
  // flags and pointers
  // ---------------------------------------------------------------
  // count is one bit wider than the pointers so that a full buffer is told apart from an empty one
  assign in_s.ready = (count != (AW+1)'(D));
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rd_ptr];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage has no reset; words are only read behind valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end
endmodule
`default_nettype wire

// ---- core/nstpf_framer.sv ----
// status, time and accuracy payload framer
`timescale 1ns/1ns
`default_nettype none
module nstpf_framer
  import nstpf_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic PKT_REQ_I,
  input wire logic [7:0] PKT_ID_I,
  input wire logic [3:0] FILTER_INIT_I,
  input wire logic [2:0] FIX_CODE_I,
  input wire logic [1:0] EVENT_I,
  input wire logic EVENT_CLR_I,
  input wire logic [6:0] AIDING_I,
  input wire logic [15:0] FAULT_I,
  input wire logic [31:0] UNIX_SEC_I,
  input wire logic [31:0] USEC_I,
  input wire logic [15:0] YEAR_I,
  input wire logic [15:0] YEAR_DAY_I,
  input wire logic [7:0] MONTH_I,
  input wire logic [7:0] MDAY_I,
  input wire logic [7:0] WDAY_I,
  input wire logic [7:0] HOUR_I,
  input wire logic [7:0] MINUTE_I,
  input wire logic [7:0] SECOND_I,
  input wire logic [95:0] POS_SD_I,
  input wire logic [95:0] VEL_SD_I,
  input wire logic TX_READY_I,
  output logic [7:0] TX_DATA_O,
  output logic TX_LAST_O,
  output logic TX_VALID_O,
  output logic [15:0] FILTER_WORD_O,
  output logic PKT_BUSY_O,
  output logic PKT_REJECT_O,
  output logic RANGE_ERR_O
);
  nstpf_state_t state, next_state;
  logic [PAYLOAD_BITS-1:0] payload, next_payload, build;
  logic [3:0] len, next_len, build_len;
  logic [3:0] idx, next_idx;
  logic [1:0] events, next_events;
  logic [15:0] filter_word, next_filter_word;
  logic reject, next_reject, range_err, next_range_err;
  logic known, accept, push, cal_bad;
  logic [31:0] usec_c;

  nstpf_stream_if #(.W(FIFO_WIDTH)) to_fifo ();
  nstpf_stream_if #(.W(FIFO_WIDTH)) from_fifo ();

  // ---------------------------------------------------------------
  // field conditioning
  // ---------------------------------------------------------------
  // clamp rather than wrap: a bad count must never roll into the seconds
  assign usec_c = (USEC_I > USEC_MAX) ? USEC_MAX : USEC_I;
  assign cal_bad = (YEAR_DAY_I > YEAR_DAY_MAX) || (MONTH_I > MONTH_MAX) ||
                   (MDAY_I < MDAY_MIN) || (MDAY_I > MDAY_MAX) || (WDAY_I > WDAY_MAX) ||
                   (HOUR_I > HOUR_MAX) || (MINUTE_I > MINSEC_MAX) || (SECOND_I > MINSEC_MAX);

  // ---------------------------------------------------------------
  // payload assembly, byte k at bits 8k+7:8k
  // ---------------------------------------------------------------
  always_comb begin
    build = '0;
    build_len = LEN_EPOCH;
    known = 1'b1;
    unique case (PKT_ID_I)
      ID_EPOCH: begin
        build = {48'h0, usec_c, UNIX_SEC_I};
      end
      ID_CALENDAR: begin
        build = {SECOND_I, MINUTE_I, HOUR_I, WDAY_I, MDAY_I, MONTH_I,
                 YEAR_DAY_I, YEAR_I, usec_c};
        build_len = LEN_CALENDAR;
      end
      ID_STATUS: begin
        build = {80'h0, filter_word, FAULT_I};
        build_len = LEN_STATUS;
      end
      ID_POS_SD: begin
        build = {16'h0, POS_SD_I};
        build_len = LEN_SD;
      end
      ID_VEL_SD: begin
        build = {16'h0, VEL_SD_I};
        build_len = LEN_SD;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // filter word and sticky events
  // ---------------------------------------------------------------
  always_comb begin
    // set wins over clear so an event in the clear cycle survives
    next_events = (EVENT_CLR_I ? 2'h0 : events) | EVENT_I;
    next_filter_word = {AIDING_I, events, FIX_CODE_I, FILTER_INIT_I};
  end

  // ---------------------------------------------------------------
  // request and send sequencer
  // ---------------------------------------------------------------
  assign accept = (state == ST_IDLE) && PKT_REQ_I && known;
  assign push = (state == ST_SEND) && to_fifo.ready;
  assign to_fifo.valid = (state == ST_SEND);
  assign to_fifo.data = {idx == len - 4'h1, payload[idx*8 +: 8]};

  always_comb begin
    next_state = state;
    next_payload = payload;
    next_len = len;
    next_idx = idx;
    next_reject = 1'b0;
    next_range_err = range_err;
    unique case (state)
      ST_IDLE: begin
        // requests while busy are dropped; the caller watches the busy flag
        if (PKT_REQ_I) begin
          next_reject = !known;
        end
        if (accept) begin
          next_state = ST_SEND;
          next_payload = build;
          next_len = build_len;
          next_idx = 4'h0;
          if (PKT_ID_I == ID_CALENDAR) begin
            next_range_err = cal_bad;
          end
        end
      end
      ST_SEND: begin
        if (push) begin
          next_idx = idx + 4'h1;
          if (idx == len - 4'h1) begin
            next_state = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      payload <= '0;
      len <= 4'h0;
      idx <= 4'h0;
      events <= 2'h0;
      filter_word <= FILTER_RESET;
      reject <= 1'b0;
      range_err <= 1'b0;
    end else begin
      state <= next_state;
      payload <= next_payload;
      len <= next_len;
      idx <= next_idx;
      events <= next_events;
      filter_word <= next_filter_word;
      reject <= next_reject;
      range_err <= next_range_err;
    end
  end

  // ---------------------------------------------------------------
  // output buffer
  // ---------------------------------------------------------------
  nstpf_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .in_s(to_fifo),
    .out_s(from_fifo)
  );

  assign from_fifo.ready = TX_READY_I;
  assign TX_VALID_O = from_fifo.valid;
  assign TX_DATA_O = from_fifo.data[7:0];
  assign TX_LAST_O = from_fifo.data[8];
  assign FILTER_WORD_O = filter_word;
  assign PKT_BUSY_O = (state != ST_IDLE);
  assign PKT_REJECT_O = reject;
  assign RANGE_ERR_O = range_err;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  chk_init_aid_bits: assert property (!$past(RST_I) |->
    FILTER_WORD_O[3:0] == $past(FILTER_INIT_I) && FILTER_WORD_O[15:9] == $past(AIDING_I))
    else $error("filter init or aiding bits wrong");
  chk_event_sticky: assert property (EVENT_I[0] |-> ##2 FILTER_WORD_O[7])
    else $error("event flag not reported");
  chk_fix_field: assert property (!$past(RST_I) |-> FILTER_WORD_O[6:4] == $past(FIX_CODE_I))
    else $error("fix code misplaced");
  chk_epoch_secs: assert property (accept && PKT_ID_I == ID_EPOCH |=>
    payload[31:0] == $past(UNIX_SEC_I) && len == LEN_EPOCH)
    else $error("epoch payload wrong");
  chk_usec_clamp: assert property (accept && PKT_ID_I == ID_EPOCH && USEC_I > USEC_MAX |=>
    payload[63:32] == USEC_MAX)
    else $error("microseconds not clamped");
  chk_calendar_len: assert property (accept && PKT_ID_I == ID_CALENDAR |=>
    len == LEN_CALENDAR && payload[47:32] == $past(YEAR_I) && payload[111:104] == $past(SECOND_I))
    else $error("calendar payload wrong");
  chk_month_range: assert property (accept && PKT_ID_I == ID_CALENDAR && MONTH_I > MONTH_MAX |=>
    RANGE_ERR_O)
    else $error("month range not flagged");
  chk_status_pair: assert property (accept && PKT_ID_I == ID_STATUS |=>
    len == LEN_STATUS && payload[15:0] == $past(FAULT_I) && payload[31:16] == $past(filter_word))
    else $error("status payload wrong");
  chk_pos_sd: assert property (accept && PKT_ID_I == ID_POS_SD |=>
    len == LEN_SD && payload[95:0] == $past(POS_SD_I))
    else $error("position accuracy payload wrong");
  chk_vel_sd: assert property (accept && PKT_ID_I == ID_VEL_SD |=>
    len == LEN_SD && payload[95:0] == $past(VEL_SD_I))
    else $error("velocity accuracy payload wrong");
  chk_lsb_first: assert property (accept && PKT_ID_I == ID_EPOCH |=>
    to_fifo.data[7:0] == $past(UNIX_SEC_I[7:0]) && to_fifo.data[8] == 1'b0)
    else $error("first byte not least significant");
  chk_send_ends: assert property (accept |=> PKT_BUSY_O ##[1:40] !PKT_BUSY_O)
    else $error("packet send did not end");
endmodule
`default_nettype wire

// ---- verification/nstpf_host_model.sv ----
// host side byte sink that may stall the payload stream
`timescale 1ns/1ns
`default_nettype none
module nstpf_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  output logic ready_o
);
  int seed = 7;
  int r;
  // ---------------------------------------------------------------
  // ready generation
  // ---------------------------------------------------------------
  // ready is low in reset, then held high unless stall_i is set; while stalled it follows a random bit
  always @(posedge clk_i) begin
    r = $random(seed);
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !stall_i || r[0];
    end
  end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the status and time payload framer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import nstpf_pkg::*;
  logic SYS_CLK_I = 0, RST_I = 1, PKT_REQ_I = 0, EVENT_CLR_I = 0, TX_READY_I, stall = 0;
  logic [7:0] PKT_ID_I = 0, MONTH_I = 0, MDAY_I = 1, WDAY_I = 0, HOUR_I = 0, MINUTE_I = 0, SECOND_I = 0;
  logic [3:0] FILTER_INIT_I = 0;
  logic [2:0] FIX_CODE_I = 0;
  logic [1:0] EVENT_I = 0, ev = 0;
  logic [6:0] AIDING_I = 0;
  logic [15:0] FAULT_I = 0, YEAR_I = 0, YEAR_DAY_I = 0, FILTER_WORD_O;
  logic [31:0] UNIX_SEC_I = 0, USEC_I = 0;
  logic [95:0] POS_SD_I = 0, VEL_SD_I = 0;
  logic [7:0] TX_DATA_O;
  logic TX_LAST_O, TX_VALID_O, PKT_BUSY_O, PKT_REJECT_O, RANGE_ERR_O;
  logic [8:0] exp[$];
  int seed = 32'h48e0db80;
  int n_mismatch = 0;
  int checks = 0;

  always #20 SYS_CLK_I = ~SYS_CLK_I;

  nstpf_framer DUT (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PKT_REQ_I(PKT_REQ_I), .PKT_ID_I(PKT_ID_I),
    .FILTER_INIT_I(FILTER_INIT_I), .FIX_CODE_I(FIX_CODE_I), .EVENT_I(EVENT_I), .EVENT_CLR_I(EVENT_CLR_I),
    .AIDING_I(AIDING_I), .FAULT_I(FAULT_I), .UNIX_SEC_I(UNIX_SEC_I), .USEC_I(USEC_I), .YEAR_I(YEAR_I),
    .YEAR_DAY_I(YEAR_DAY_I), .MONTH_I(MONTH_I), .MDAY_I(MDAY_I), .WDAY_I(WDAY_I), .HOUR_I(HOUR_I),
    .MINUTE_I(MINUTE_I), .SECOND_I(SECOND_I), .POS_SD_I(POS_SD_I), .VEL_SD_I(VEL_SD_I),
    .TX_READY_I(TX_READY_I), .TX_DATA_O(TX_DATA_O), .TX_LAST_O(TX_LAST_O), .TX_VALID_O(TX_VALID_O),
    .FILTER_WORD_O(FILTER_WORD_O), .PKT_BUSY_O(PKT_BUSY_O), .PKT_REJECT_O(PKT_REJECT_O),
    .RANGE_ERR_O(RANGE_ERR_O));
  nstpf_host_model host (.clk_i(SYS_CLK_I), .rst_i(RST_I), .stall_i(stall), .ready_o(TX_READY_I));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] want, input logic [31:0] got);
    checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic put(input logic [111:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      exp.push_back({1'b0, v[8*i +: 8]});
    end
  endtask

  // expected payload, lsb first, from the values held at the request
  task automatic build(input logic [7:0] id);
    logic [31:0] us;
    us = (USEC_I > USEC_MAX) ? USEC_MAX : USEC_I;
    case (id)
      ID_EPOCH: begin
        put({48'h0, us, UNIX_SEC_I}, 8);
      end
      ID_CALENDAR: begin
        put({SECOND_I, MINUTE_I, HOUR_I, WDAY_I, MDAY_I, MONTH_I, YEAR_DAY_I, YEAR_I, us}, 14);
      end
      ID_STATUS: put({80'h0, AIDING_I, ev, FIX_CODE_I, FILTER_INIT_I, FAULT_I}, 4);
      ID_POS_SD: put({16'h0, POS_SD_I}, 12);
      ID_VEL_SD: put({16'h0, VEL_SD_I}, 12);
      default: ;
    endcase
    if (exp.size() != 0) begin
      exp[exp.size()-1][8] = 1'b1;
    end
  endtask

  task automatic req(input logic [7:0] id);
    int n;
    build(id);
    @(posedge SYS_CLK_I);
    PKT_REQ_I <= 1'b1;
    PKT_ID_I <= id;
    @(posedge SYS_CLK_I);
    PKT_REQ_I <= 1'b0;
    n = 0;
    while ((exp.size() != 0 || PKT_BUSY_O !== 1'b0) && n < 600) begin
      @(posedge SYS_CLK_I);
      n++;
    end
    chk(0, n / 600);
  endtask

  task automatic rnd();
    @(posedge SYS_CLK_I);
    FAULT_I <= 16'($random(seed));
    UNIX_SEC_I <= $random(seed);
    USEC_I <= {$random(seed)} % 1000000;
    YEAR_I <= 16'($random(seed));
    YEAR_DAY_I <= 16'({$random(seed)} % 366);
    MONTH_I <= 8'({$random(seed)} % 12);
    MDAY_I <= 8'(1 + {$random(seed)} % 31);
    WDAY_I <= 8'({$random(seed)} % 7);
    HOUR_I <= 8'({$random(seed)} % 24);
    MINUTE_I <= 8'({$random(seed)} % 60);
    SECOND_I <= 8'({$random(seed)} % 60);
    POS_SD_I <= {$random(seed), $random(seed), $random(seed)};
    VEL_SD_I <= {$random(seed), $random(seed), $random(seed)};
    stall <= 1'($random(seed));
  endtask

  // ---------------------------------------------------------------
  // byte monitor
  // ---------------------------------------------------------------
  always @(posedge SYS_CLK_I) begin
    if (!RST_I && TX_VALID_O === 1'b1 && TX_READY_I === 1'b1) begin
      if (exp.size() == 0) begin
        chk(32'h200, {TX_LAST_O, TX_DATA_O});
      end else begin
        chk(exp.pop_front(), {TX_LAST_O, TX_DATA_O});
      end
    end
  end

  // cuts a hang short: 20000 cycles is several times the planned run
  initial begin
    #800000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
    for (int f = 0; f < 8; f++) begin
      @(posedge SYS_CLK_I);
      FIX_CODE_I <= f[2:0];
      FILTER_INIT_I <= 4'($random(seed));
      AIDING_I <= 7'($random(seed));
      repeat (3) @(posedge SYS_CLK_I);
      chk({AIDING_I, ev, FIX_CODE_I, FILTER_INIT_I}, FILTER_WORD_O);
    end
    EVENT_I <= 2'h3;
    @(posedge SYS_CLK_I);
    EVENT_I <= 2'h0;
    ev = 2'h3;
    repeat (3) @(posedge SYS_CLK_I);
    chk({AIDING_I, ev, FIX_CODE_I, FILTER_INIT_I}, FILTER_WORD_O);
    $display("filter word test done");
    for (int k = 0; k < 20; k++) begin
      rnd();
      if (k == 5) begin
        USEC_I <= 32'hFFFFFFFF;
      end
      @(posedge SYS_CLK_I);
      req(8'(21 + k % 5));
      if (k % 5 == 1) begin
        chk(0, RANGE_ERR_O);
      end
    end
    $display("payload test done");
    EVENT_CLR_I <= 1'b1;
    @(posedge SYS_CLK_I);
    EVENT_CLR_I <= 1'b0;
    ev = 2'h0;
    repeat (3) @(posedge SYS_CLK_I);
    chk({AIDING_I, ev, FIX_CODE_I, FILTER_INIT_I}, FILTER_WORD_O);
    req(ID_STATUS);
    MONTH_I <= 8'h0C;
    @(posedge SYS_CLK_I);
    req(ID_CALENDAR);
    chk(1, RANGE_ERR_O);
    @(posedge SYS_CLK_I);
    PKT_REQ_I <= 1'b1;
    PKT_ID_I <= 8'h30;
    @(posedge SYS_CLK_I);
    PKT_REQ_I <= 1'b0;
    #1;
    chk(1, PKT_REJECT_O);
    repeat (5) @(posedge SYS_CLK_I);
    $display("range and reject test done");
    stop_test();
  end
endmodule
`default_nettype wire
